// [logic/svw_top.sv]
// Supply supervisor core: reset generation, manual reset debounce, watchdog,
// write protection and page-buffered memory write path.
// Assumes pins arrive asynchronous; write requests come from same-clock logic.
//
// Contract
// - Watchdog expiry after 1.6 s forces reset
// - Without kick pin, data line activity restarts watchdog
// - Either kick edge restarts; host kicks within 1.6 s
// - Manual reset low asserts reset outputs
// - Reset held while low, then one timeout
// - Manual reset input is debounced first
// - External pull on reset pin starts reset
// - Reset released 200 ms after supply recovers
// - Supply low drives both reset outputs active
// - Write protect high blocks all array writes
// - Supply below threshold inhibits all writes
// - Page writes up to 16 bytes, 2k-bit array
// - Reduced option: low output only, no protect
// - Write cycle 5 ms ignores bus access; the code still serves rd_addr reads during the write cycle
`timescale 1ns/10ps
`default_nettype none

module svw_top
  import svw_pkg::*;
#(
  parameter bit HAS_KICK_PIN = 1'b0,
  parameter bit REDUCED = 1'b0,
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned WDOG_T = WDOG_TICKS,
  parameter int unsigned RST_T = RST_TICKS,
  parameter int unsigned WRC_T = WRITE_TICKS,
  parameter int unsigned DEB_T = DEBOUNCE_TICKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire svw_pins_type pins_in,
  input wire svw_wr_req_type wr_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic reset_high_out,
  output logic reset_low_out,
  output logic reset_low_oe,
  output logic write_allow,
  output logic bus_busy
);

  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam int unsigned CNT_W = $clog2(WDOG_T + 1);

  // ********************************************************************
  // Parameter checks
  // ********************************************************************
  if (TICK_CYC < 2 || WDOG_T < 2 || RST_T < 1 || WRC_T < 1 || DEB_T < 1 ||
      RST_T > WDOG_T || WRC_T > WDOG_T || DEB_T > WDOG_T) begin : g_bad_param
    $error("svw_top: tick counts out of range");
  end

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    svw_pins_type s1;
    svw_pins_type s2;
    logic watch_d;
    logic [TW-1:0] pre;
    logic tick;
    logic mr_deb;
    logic [CNT_W-1:0] deb_cnt;
    logic [CNT_W-1:0] wdog_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] wrc_cnt;
    logic rst;
    logic hi;
    logic [2:0] drv_hist;
    logic busy;
    logic allow;
    logic [ADDR_W-1:0] pg_addr;
    logic [PAGE_BYTES-1:0] pg_vld;
    logic [PAGE_BYTES-1:0][7:0] pg_buf;
    logic [ARRAY_BYTES-1:0][7:0] mem;
    logic [7:0] rd;
  } svw_state_type;

  svw_state_type st;
  svw_state_type next_st;
  logic watch;
  logic kick;
  logic ext_low;
  logic wdog_exp;
  logic src;
  logic [PG_W-1:0] off;

  function automatic logic at_end(input logic [CNT_W-1:0] c, input int unsigned lim);
    return c == CNT_W'(lim - 1);
  endfunction

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    next_st = st;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    // Shared time base
    next_st.tick = (st.pre == TW'(TICK_CYC - 1));
    next_st.pre = next_st.tick ? '0 : st.pre + 1'b1;
    // Watched line, any transition counts
    watch = HAS_KICK_PIN ? st.s2.watchdog_kick_in : st.s2.sda;
    next_st.watch_d = watch;
    kick = watch ^ st.watch_d;
    // Manual reset debounce
    if (st.s2.manual_reset_in_n == st.mr_deb) begin
      next_st.deb_cnt = '0;
    end else if (st.tick) begin
      if (at_end(st.deb_cnt, DEB_T)) begin
        next_st.mr_deb = st.s2.manual_reset_in_n;
        next_st.deb_cnt = '0;
      end else begin
        next_st.deb_cnt = st.deb_cnt + 1'b1;
      end
    end
    // Pin low while nothing of ours drives it
    ext_low = !st.s2.reset_pin && (st.drv_hist == '0) && !st.rst;
    wdog_exp = st.tick && at_end(st.wdog_cnt, WDOG_T) && !st.rst;
    src = st.s2.supply_low || !st.mr_deb || ext_low || wdog_exp;
    // Reset hold
    if (src) begin
      next_st.rst = 1'b1;
      next_st.hold_cnt = '0;
    end else if (st.rst && st.tick) begin
      if (at_end(st.hold_cnt, RST_T)) begin
        next_st.rst = 1'b0;
        next_st.hold_cnt = '0;
      end else begin
        next_st.hold_cnt = st.hold_cnt + 1'b1;
      end
    end
    next_st.hi = next_st.rst && !REDUCED;
    next_st.drv_hist = {st.drv_hist[1:0], st.rst};
    // Watchdog
    if (st.rst || kick || wdog_exp) begin
      next_st.wdog_cnt = '0;
    end else if (st.tick) begin
      next_st.wdog_cnt = st.wdog_cnt + 1'b1;
    end
    // Write cycle timer
    if (st.busy && st.tick) begin
      if (at_end(st.wrc_cnt, WRC_T)) begin
        next_st.busy = 1'b0;
        next_st.wrc_cnt = '0;
      end else begin
        next_st.wrc_cnt = st.wrc_cnt + 1'b1;
      end
    end
    // Page buffer load, offsets wrap inside the page
    off = (st.pg_vld == '0) ? wr_req.addr[PG_W-1:0] : st.pg_addr[PG_W-1:0];
    if (wr_req.load && !st.busy) begin
      if (st.pg_vld == '0) begin
        next_st.pg_addr = wr_req.addr;
      end else begin
        next_st.pg_addr = {st.pg_addr[ADDR_W-1:PG_W], PG_W'(st.pg_addr[PG_W-1:0] + 1'b1)};
      end
      if (st.pg_vld == '0) begin
        next_st.pg_addr = {wr_req.addr[ADDR_W-1:PG_W], PG_W'(wr_req.addr[PG_W-1:0] + 1'b1)};
      end
      next_st.pg_buf[off] = wr_req.data;
      next_st.pg_vld[off] = 1'b1;
    end
    // Commit on stop: if writes allowed, copy valid bytes and start write cycle; page is dropped either way
    if (wr_req.commit && !st.busy && st.pg_vld != '0) begin
      if (st.allow) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (st.pg_vld[i]) begin
            next_st.mem[{st.pg_addr[ADDR_W-1:PG_W], PG_W'(i)}] = st.pg_buf[i];
          end
        end
        next_st.busy = 1'b1;
        next_st.wrc_cnt = '0;
      end
      next_st.pg_vld = '0;
    end
    next_st.allow = !st.s2.supply_low && !(st.s2.write_protect && !REDUCED);
    next_st.rd = st.mem[rd_addr];
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.s1 <= SYNC_RST;
      st.s2 <= SYNC_RST;
      // Idle level of the watched line, so no false edge after reset
      st.watch_d <= !HAS_KICK_PIN;
      st.mr_deb <= 1'b1;
      st.rst <= 1'b1;
      st.hi <= !REDUCED;
    end else begin
      st <= next_st;
    end
  end

  assign reset_high_out = st.hi;
  assign reset_low_out = 1'b0;
  assign reset_low_oe = st.rst;
  assign write_allow = st.allow;
  assign bus_busy = st.busy;
  assign rd_data = st.rd;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_supply_reset: assert property (st.s2.supply_low |=> reset_low_oe && (reset_high_out == !REDUCED))
    else $error("supply low did not assert both resets");
  chk_output_pair: assert property (reset_high_out == (reset_low_oe && !REDUCED))
    else $error("reset outputs disagree");
  chk_protect_block: assert property (st.s2.write_protect && !REDUCED |=> !write_allow)
    else $error("write allowed while protected");
  chk_supply_block: assert property (st.s2.supply_low |=> !write_allow ##1 !$rose(bus_busy))
    else $error("write allowed at low supply");
  chk_busy_ignore: assert property (bus_busy && wr_req.load |=> $stable(st.pg_vld))
    else $error("page load taken during write cycle");
  chk_manual_hold: assert property (!st.mr_deb |=> reset_low_oe [*2])
    else $error("manual reset not held");
  chk_release_wait: assert property ($fell(reset_low_oe) |-> $past(at_end(st.hold_cnt, RST_T), 1)
    && $past(st.tick, 1))
    else $error("reset released before timeout");
  chk_wdog_expire: assert property (wdog_exp |=> reset_low_oe && st.wdog_cnt == '0)
    else $error("watchdog expiry did not reset");
  chk_kick_restart: assert property (kick && !wdog_exp |=> st.wdog_cnt == '0)
    else $error("kick did not restart watchdog");
  chk_ext_trigger: assert property (ext_low |=> reset_low_oe ##1 reset_low_oe)
    else $error("external pull did not start reset");
  chk_commit_busy: assert property (wr_req.commit && !bus_busy && st.pg_vld != '0 && write_allow
    |=> bus_busy && st.pg_vld == '0)
    else $error("commit did not start write cycle");
  chk_new_source: assert property (src |=> st.hold_cnt == '0)
    else $error("hold count not restarted");

  cov_release: cover property ($fell(reset_low_oe));
  cov_wdog: cover property (wdog_exp);
  cov_ext: cover property (ext_low);
  cov_commit: cover property ($rose(bus_busy));

endmodule // svw_top

`default_nettype wire

// [logic/svw_pkg.sv]
// Constants and carriers of the supply supervisor, watchdog and memory write gate.
// Assumes one 40 MHz clock; all timing is counted in ticks of a common time base.
package svw_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS = 100_000;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned RST_TIMEOUT_MS = 200;
  localparam int unsigned WRITE_CYCLE_MS = 5;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned WDOG_TICKS = WDOG_TIMEOUT_MS * NS_PER_MS / TICK_NS;
  localparam int unsigned RST_TICKS = (RST_TIMEOUT_MS * NS_PER_MS + TICK_NS - 1) / TICK_NS;
  localparam int unsigned WRITE_TICKS = WRITE_CYCLE_MS * NS_PER_MS / TICK_NS;
  localparam int unsigned DEBOUNCE_TICKS = (DEBOUNCE_MS * NS_PER_MS + TICK_NS - 1) / TICK_NS;

  // ********************************************************************
  // Memory geometry
  // ********************************************************************
  localparam int unsigned ARRAY_BITS = 2048;
  localparam int unsigned ARRAY_BYTES = ARRAY_BITS / 8;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned ADDR_W = $clog2(ARRAY_BYTES);
  localparam int unsigned PG_W = $clog2(PAGE_BYTES);

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic supply_low;
    logic manual_reset_in_n;
    logic watchdog_kick_in;
    logic sda;
    logic reset_pin;
    logic write_protect;
  } svw_pins_type;

  typedef struct packed {
    logic load;
    logic commit;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } svw_wr_req_type;

  // Synchroniser reset: supply low, pull-ups high, pull-down low
  localparam svw_pins_type SYNC_RST = '{
    supply_low: 1'b1, manual_reset_in_n: 1'b1, watchdog_kick_in: 1'b0,
    sda: 1'b1, reset_pin: 1'b1, write_protect: 1'b0};

endpackage

// [verification/svw_host_model.sv]
// Host side model: kicks the watchdog and can pull the reset wire low.
// Assumes the reset wire has a pull-up and only this model and the block drive it.
`timescale 1ns/10ps
`default_nettype none

module svw_host_model
  import svw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_low_oe,
  input wire logic kick_en,
  input wire logic pull_low,
  output logic watchdog_kick_in,
  output logic reset_pin
);
  logic [5:0] kick_cnt;

  // Open-drain wire, pull-up when nobody drives
  assign reset_pin = !(reset_low_oe || pull_low);

  // Toggle the kick line every 64 cycles while enabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kick_cnt <= 6'h00;
      watchdog_kick_in <= 1'b0;
    end else if (kick_en) begin
      kick_cnt <= kick_cnt + 6'h01;
      if (kick_cnt == 6'h3F) watchdog_kick_in <= !watchdog_kick_in;
    end
  end
endmodule // svw_host_model

`default_nettype wire

// [verification/tb.sv]
// Self-checking bench of the supervisor core with small timing parameters.
// Assumes svw_top with TICK_CYC=4, RST_T=8, WDOG_T=40, WRC_T=3, DEB_T=2.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import svw_pkg::*;
  logic clk, arst_n, sup, mr_n, wp, kick_en, pull_low, kick, rpin;
  logic rh, rl, roe, wa, busy;
  logic [7:0] rd_data, rd_addr, got;
  svw_wr_req_type wr_req;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  // Small timing so every timeout fits in a short run
  localparam int unsigned TB_TICK = 4;
  localparam int unsigned TB_WDOG = 40;
  localparam int unsigned TB_RST = 8;
  localparam int unsigned TB_WRC = 3;
  localparam int unsigned TB_DEB = 2;

  svw_top #(.HAS_KICK_PIN(1'b1), .TICK_CYC(TB_TICK), .WDOG_T(TB_WDOG), .RST_T(TB_RST),
    .WRC_T(TB_WRC), .DEB_T(TB_DEB)) u_svw_top (.clk(clk), .arst_n(arst_n),
    .pins_in('{supply_low: sup, manual_reset_in_n: mr_n, watchdog_kick_in: kick, sda: 1'b1,
      reset_pin: rpin, write_protect: wp}),
    .wr_req(wr_req), .rd_addr(rd_addr), .rd_data(rd_data), .reset_high_out(rh),
    .reset_low_out(rl), .reset_low_oe(roe), .write_allow(wa), .bus_busy(busy));
  svw_host_model u_svw_host_model (.clk(clk), .arst_n(arst_n), .reset_low_oe(roe),
    .kick_en(kick_en), .pull_low(pull_low), .watchdog_kick_in(kick), .reset_pin(rpin));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_rst(input logic v, input int lim);
    int i;
    i = 0;
    #1;
    while (roe !== v && i < lim) begin
      hold(1);
      i++;
    end
    chk("reset_low_oe", {7'h00, v}, {7'h00, roe});
    chk("reset_high_out", {7'h00, v}, {7'h00, rh});
    chk("reset_low_out", 8'h00, {7'h00, rl});
  endtask

  task automatic wr_page(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
      input logic exp_busy);
    @(posedge clk) wr_req <= '{load: 1'b1, commit: 1'b0, addr: a, data: d0};
    @(posedge clk) wr_req <= '{load: 1'b1, commit: 1'b0, addr: 8'h00, data: d1};
    @(posedge clk) wr_req <= '{load: 1'b0, commit: 1'b1, addr: 8'h00, data: 8'h00};
    @(posedge clk) wr_req <= '0;
    #1;
    chk("bus_busy", {7'h00, exp_busy}, {7'h00, busy});
    hold(20);
    chk("bus_busy end", 8'h00, {7'h00, busy});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk) rd_addr <= a;
    hold(2);
    got = rd_data;
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_power_up();
    hold(3);
    wait_rst(1'b1, 0);
    wr_page(8'h40, 8'h11, 8'h22, 1'b0);
    @(posedge clk) sup <= 1'b0;
    hold(20);
    wait_rst(1'b1, 0);
    wait_rst(1'b0, 40);
    chk("write_allow", 8'h01, {7'h00, wa});
  endtask

  task automatic t_writes();
    wr_page(8'h25, 8'hA5, 8'h5A, 1'b1);
    rd(8'h25);
    chk("mem 25", 8'hA5, got);
    rd(8'h26);
    chk("mem 26", 8'h5A, got);
    @(posedge clk) wp <= 1'b1;
    hold(5);
    wr_page(8'h25, 8'h33, 8'h44, 1'b0);
    rd(8'h25);
    chk("mem protected", 8'hA5, got);
    @(posedge clk) wp <= 1'b0;
  endtask

  task automatic t_manual();
    @(posedge clk) mr_n <= 1'b0;
    @(posedge clk) mr_n <= 1'b0;
    @(posedge clk) mr_n <= 1'b1;
    hold(20);
    wait_rst(1'b0, 0);
    @(posedge clk) mr_n <= 1'b0;
    wait_rst(1'b1, 20);
    hold(30);
    @(posedge clk) mr_n <= 1'b1;
    hold(30);
    wait_rst(1'b1, 0);
    wait_rst(1'b0, 60);
  endtask

  task automatic t_pin_and_supply();
    @(posedge clk) pull_low <= 1'b1;
    wait_rst(1'b1, 6);
    hold(8);
    @(posedge clk) pull_low <= 1'b0;
    wait_rst(1'b0, 60);
    @(posedge clk) sup <= 1'b1;
    wait_rst(1'b1, 4);
    @(posedge clk) sup <= 1'b0;
    wait_rst(1'b0, 60);
  endtask

  task automatic t_watchdog();
    int hits;
    hits = 0;
    repeat (400) begin
      hold(1);
      if (roe !== 1'b0) hits++;
    end
    chk("resets while kicked", 8'h00, hits[7:0]);
    @(posedge clk) kick_en <= 1'b0;
    wait_rst(1'b1, 230);
    @(posedge clk) kick_en <= 1'b1;
    wait_rst(1'b0, 60);
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    arst_n = 1'b0;
    sup = 1'b1;
    mr_n = 1'b1;
    wp = 1'b0;
    kick_en = 1'b1;
    pull_low = 1'b0;
    rd_addr = 8'h00;
    wr_req = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_power_up();
    t_writes();
    t_manual();
    t_pin_and_supply();
    t_watchdog();
    conclude();
  end
endmodule // tb

`default_nettype wire
